// file: vadc_pkg.sv
`default_nettype none
package vadc_pkg;
  localparam int CODE_W = 8;
  localparam int NUM_CH = 3;
  localparam int THERM_W = 256;
  localparam int DITHER_W = 2;
  localparam int FIFO_DEPTH = 32;
  localparam int WORD_W = CODE_W * NUM_CH;
  // channel slots in the packed word
  localparam int CH_RED = 0;
  localparam int CH_GREEN = 1;
  localparam int CH_BLUE = 2;
  // clamp levels in 1/256 of full range
  localparam logic [7:0] CLAMP_LOW = 8'h10;
  localparam logic [7:0] CLAMP_MID = 8'h80;
  localparam logic [7:0] CLAMP_QTR = 8'h40;
  // code range limits
  localparam logic [7:0] CODE_MIN = 8'h00;
  localparam logic [7:0] CODE_LOW1 = 8'h01;
  localparam logic [7:0] CODE_TOPM1 = 8'hfe;
  localparam logic [7:0] CODE_MAX = 8'hff;
  localparam logic [1:0] DITHER_RST = 2'h0;
  localparam logic [2:0] CLAMP_NONE = 3'h0;
  // sample clock rises from capture to output: 2.5 sample periods
  localparam int OUT_RISES = 3;
  localparam int REF_PERIOD_PS = 4000;
  typedef enum logic [2:0] {
    CL_IDLE = 3'b001,
    CL_INTEG = 3'b010,
    CL_CORRECT = 3'b100
  } clamp_state_e;
endpackage
`default_nettype wire

// file: vadc_stream_if.sv
`timescale 1ns/1ps
`default_nettype none
interface vadc_stream_if #(parameter int W = 24);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport src (output data, output valid, input ready);
  modport snk (input data, input valid, output ready);
endinterface
`default_nettype wire

// file: vadc_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module vadc_fifo #(
  parameter int WIDTH = 24,
  parameter int DEPTH = 32
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  vadc_stream_if.snk in_s,
  vadc_stream_if.src out_s
);
  localparam int AW = $clog2(DEPTH);

  // refused at elaboration: pointer wrap needs a power-of-two depth
  if (DEPTH < 2 || (1 << AW) != DEPTH || WIDTH < 1) begin
    $error("fifo depth must be a power of two, at least 2");
  end

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0] wr_r;
  logic [AW:0] rd_r;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign full = (wr_r[AW] != rd_r[AW]) && (wr_r[AW-1:0] == rd_r[AW-1:0]);
  assign empty = (wr_r == rd_r);
  assign in_s.ready = !full;
  assign out_s.valid = !empty;
  assign out_s.data = mem[rd_r[AW-1:0]];
  assign push = in_s.valid && !full;
  assign pop = out_s.ready && !empty;

  always_ff @(posedge i_clk) begin
    if (push) begin
      mem[wr_r[AW-1:0]] <= in_s.data;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      wr_r <= '0;
    end else if (push) begin
      wr_r <= wr_r + 1'b1;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_r <= '0;
    end else if (pop) begin
      rd_r <= rd_r + 1'b1;
    end
  end

  a_fifo_bound: assert property (@(posedge i_clk) disable iff (!i_rst_n)
    full |=> (wr_r == $past(wr_r)) || $past(pop))
    else $error("fifo written while full");
endmodule
`default_nettype wire

// file: vadc_ctrl.sv
//////////////////////////////////////////////////////////////////////////////
// Summary of operation
// - each channel encodes 255 comparators (therm bits 1..255) to 8 bits
// - one sample clock and syncs for all channels
// - sample on falling, outputs change on rising
// - code appears 2.5 sample cycles after capture
// - outputs driven only while select low
// - dither counter reset every second frame pulse
// - dither counter steps once per line
// - frame sync low stops and disables dither
// - dither offset steps in half lsb units
// - whole-lsb offset subtracted from each code
// - code range 00..fe or 01..ff
// - mode low: all clamps at 16/256
// - mode high/open: chroma 128, luma 16/64
// - line sync high integrates clamp difference
// - line sync fall latches integrator sign
// - latched sign sources or sinks while low
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps
`default_nettype none
module vadc_ctrl #(
  parameter int DEPTH = vadc_pkg::FIFO_DEPTH
) (
  input wire logic I_REF_CLK,
  input wire logic I_ARST_N,
  input wire logic I_SAMPLE_CLK,
  input wire logic I_LINE_SYNC,
  input wire logic I_FRAME_SYNC,
  input wire logic I_SELECT_N,
  input wire logic I_MODE,
  input wire logic I_MODE_OPEN,
  input wire logic [vadc_pkg::THERM_W-1:0] I_RED_THERM,
  input wire logic [vadc_pkg::THERM_W-1:0] I_GREEN_THERM,
  input wire logic [vadc_pkg::THERM_W-1:0] I_BLUE_THERM,
  input wire logic [vadc_pkg::NUM_CH-1:0] I_CLAMP_SIGN,
  input wire logic I_STREAM_READY,
  output logic [vadc_pkg::CODE_W-1:0] O_RED_CODE,
  output logic [vadc_pkg::CODE_W-1:0] O_GREEN_CODE,
  output logic [vadc_pkg::CODE_W-1:0] O_BLUE_CODE,
  output logic O_CODE_OE_N,
  output logic [vadc_pkg::DITHER_W-1:0] O_DITHER_HALF_LSB,
  output logic O_DITHER_ON,
  output logic [7:0] O_CLAMP_LEVEL_RED,
  output logic [7:0] O_CLAMP_LEVEL_GREEN,
  output logic [7:0] O_CLAMP_LEVEL_BLUE,
  output logic O_CLAMP_INTEG,
  output logic [vadc_pkg::NUM_CH-1:0] O_CLAMP_SOURCE,
  output logic [vadc_pkg::NUM_CH-1:0] O_CLAMP_SINK,
  output logic [vadc_pkg::WORD_W-1:0] O_STREAM_DATA,
  output logic O_STREAM_VALID,
  output logic O_FIFO_READY
);
  localparam int CW = vadc_pkg::CODE_W;
  localparam int WW = vadc_pkg::WORD_W;
  // refused at elaboration: the fifo cannot serve fewer than two words
  if (DEPTH < 2) begin
    $error("fifo depth too small");
  end
  // thermometer to binary: highest tripped comparator wins, bubbles ignored
  function automatic logic [7:0] therm_encode(input logic [vadc_pkg::THERM_W-1:0] t);
    logic [7:0] c;
    c = vadc_pkg::CODE_MIN;
    for (int i = 1; i < vadc_pkg::THERM_W; i++) begin
      if (t[i]) begin
        c = 8'(i);
      end
    end
    return c;
  endfunction
  // remove the whole-lsb part of the offset and bound the range
  function automatic logic [7:0] dither_fix(input logic [7:0] raw, input logic whole);
    logic [7:0] c;
    c = raw;
    if (whole) begin
      c = (raw == vadc_pkg::CODE_MIN) ? vadc_pkg::CODE_MIN : raw - 8'h01;
    end else if (raw == vadc_pkg::CODE_MIN) begin
      c = vadc_pkg::CODE_LOW1;
    end
    return c;
  endfunction
  //////////////////////////////////////////////////////////////////////////////
  logic rst_meta_r;
  logic rst_n;
  always_ff @(posedge I_REF_CLK or negedge I_ARST_N) begin
    if (!I_ARST_N) begin
      rst_meta_r <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta_r <= 1'b1;
      rst_n <= rst_meta_r;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // edge detection of the sample clock and syncs
  logic sclk_r;
  logic line_r;
  logic frame_r;
  logic s_fall;
  logic s_rise;
  logic line_rise;
  logic line_fall;
  logic frame_rise;
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sclk_r <= 1'b0;
      line_r <= 1'b0;
      frame_r <= 1'b0;
    end else begin
      sclk_r <= I_SAMPLE_CLK;
      line_r <= I_LINE_SYNC;
      frame_r <= I_FRAME_SYNC;
    end
  end
  assign s_fall = sclk_r && !I_SAMPLE_CLK;
  assign s_rise = !sclk_r && I_SAMPLE_CLK;
  assign line_rise = I_LINE_SYNC && !line_r;
  assign line_fall = !I_LINE_SYNC && line_r;
  assign frame_rise = I_FRAME_SYNC && !frame_r;
  //////////////////////////////////////////////////////////////////////////////
  // dither counter; events wait for the next sample instant so offset and
  // correction always move together
  logic frame_par_r;
  logic inc_pend_r;
  logic rst_pend_r;
  logic line_evt;
  logic frame_evt;
  logic inc_apply;
  logic rst_apply;
  logic [vadc_pkg::DITHER_W-1:0] cnt_r;
  logic dither_on_r;
  logic whole;
  assign line_evt = line_rise && I_FRAME_SYNC;
  assign frame_evt = frame_rise && frame_par_r;
  assign inc_apply = s_fall && (inc_pend_r || line_evt);
  assign rst_apply = s_fall && (rst_pend_r || frame_evt);
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      frame_par_r <= 1'b0;
    end else if (frame_rise) begin
      frame_par_r <= !frame_par_r;
    end
  end
  // a new event in the applying cycle is folded in, so none is lost
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      inc_pend_r <= 1'b0;
      rst_pend_r <= 1'b0;
    end else begin
      inc_pend_r <= s_fall ? 1'b0 : (inc_pend_r || line_evt);
      rst_pend_r <= s_fall ? 1'b0 : (rst_pend_r || frame_evt);
    end
  end
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= vadc_pkg::DITHER_RST;
    end else if (rst_apply) begin
      cnt_r <= vadc_pkg::DITHER_RST;
    end else if (inc_apply) begin
      cnt_r <= cnt_r + 1'b1;
    end
  end
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      dither_on_r <= 1'b0;
    end else if (s_fall) begin
      dither_on_r <= I_FRAME_SYNC;
    end
  end
  // offset in half lsb: 0, 0.5, 1, 1.5; msb is the whole-lsb part
  assign O_DITHER_HALF_LSB = dither_on_r ? cnt_r : vadc_pkg::DITHER_RST;
  assign O_DITHER_ON = dither_on_r;
  assign whole = dither_on_r && cnt_r[vadc_pkg::DITHER_W-1];
  //////////////////////////////////////////////////////////////////////////////
  // capture at falling edge, then three rising edges to the pins
  logic [CW-1:0] cap_r [vadc_pkg::NUM_CH];
  logic [CW-1:0] p1_r [vadc_pkg::NUM_CH];
  logic [CW-1:0] p2_r [vadc_pkg::NUM_CH];
  logic [CW-1:0] out_r [vadc_pkg::NUM_CH];
  logic [CW-1:0] fix [vadc_pkg::NUM_CH];
  logic [2:0] vld_r;
  assign fix[vadc_pkg::CH_RED] = dither_fix(therm_encode(I_RED_THERM), whole);
  assign fix[vadc_pkg::CH_GREEN] = dither_fix(therm_encode(I_GREEN_THERM), whole);
  assign fix[vadc_pkg::CH_BLUE] = dither_fix(therm_encode(I_BLUE_THERM), whole);
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < vadc_pkg::NUM_CH; c++) begin
        cap_r[c] <= vadc_pkg::CODE_MIN;
      end
    end else if (s_fall) begin
      for (int c = 0; c < vadc_pkg::NUM_CH; c++) begin
        cap_r[c] <= fix[c];
      end
    end
  end
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      for (int c = 0; c < vadc_pkg::NUM_CH; c++) begin
        p1_r[c] <= vadc_pkg::CODE_MIN;
        p2_r[c] <= vadc_pkg::CODE_MIN;
        out_r[c] <= vadc_pkg::CODE_MIN;
      end
    end else if (s_rise) begin
      for (int c = 0; c < vadc_pkg::NUM_CH; c++) begin
        p1_r[c] <= cap_r[c];
        p2_r[c] <= p1_r[c];
        out_r[c] <= p2_r[c];
      end
    end
  end
  // marks pipeline stages holding a real sample since reset
  logic cap_vld_r;
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cap_vld_r <= 1'b0;
      vld_r <= 3'h0;
    end else begin
      if (s_fall) begin
        cap_vld_r <= 1'b1;
      end
      if (s_rise) begin
        vld_r <= {vld_r[1:0], cap_vld_r};
      end
    end
  end
  assign O_RED_CODE = out_r[vadc_pkg::CH_RED];
  assign O_GREEN_CODE = out_r[vadc_pkg::CH_GREEN];
  assign O_BLUE_CODE = out_r[vadc_pkg::CH_BLUE];
  assign O_CODE_OE_N = I_SELECT_N;
  //////////////////////////////////////////////////////////////////////////////
  // stream copy of each output word; a full fifo drops the word rather
  // than stalling conversion, which cannot wait
  vadc_stream_if #(.W(WW)) push_if ();
  vadc_stream_if #(.W(WW)) pop_if ();
  logic push_r;
  logic [WW-1:0] push_data_r;
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      push_r <= 1'b0;
      push_data_r <= '0;
    end else begin
      push_r <= s_rise && vld_r[1];
      if (s_rise) begin
        push_data_r <= {p2_r[vadc_pkg::CH_BLUE], p2_r[vadc_pkg::CH_GREEN],
                        p2_r[vadc_pkg::CH_RED]};
      end
    end
  end
  assign push_if.valid = push_r;
  assign push_if.data = push_data_r;
  assign pop_if.ready = I_STREAM_READY;
  vadc_fifo #(.WIDTH(WW), .DEPTH(DEPTH)) u_fifo (
    .i_clk(I_REF_CLK),
    .i_rst_n(rst_n),
    .in_s(push_if),
    .out_s(pop_if)
  );
  assign O_STREAM_DATA = pop_if.data;
  assign O_STREAM_VALID = pop_if.valid;
  assign O_FIFO_READY = push_if.ready;
  //////////////////////////////////////////////////////////////////////////////
  // clamp levels and network sequencing
  always_comb begin
    O_CLAMP_LEVEL_RED = vadc_pkg::CLAMP_LOW;
    O_CLAMP_LEVEL_GREEN = vadc_pkg::CLAMP_LOW;
    O_CLAMP_LEVEL_BLUE = vadc_pkg::CLAMP_LOW;
    if (I_MODE_OPEN) begin
      O_CLAMP_LEVEL_RED = vadc_pkg::CLAMP_MID;
      O_CLAMP_LEVEL_GREEN = vadc_pkg::CLAMP_QTR;
      O_CLAMP_LEVEL_BLUE = vadc_pkg::CLAMP_MID;
    end else if (I_MODE) begin
      O_CLAMP_LEVEL_RED = vadc_pkg::CLAMP_MID;
      O_CLAMP_LEVEL_BLUE = vadc_pkg::CLAMP_MID;
    end
  end
  vadc_pkg::clamp_state_e cl_r;
  vadc_pkg::clamp_state_e cl_nxt;
  logic [vadc_pkg::NUM_CH-1:0] sign_r;
  always_comb begin
    case (cl_r)
      vadc_pkg::CL_IDLE: cl_nxt = line_rise ? vadc_pkg::CL_INTEG : vadc_pkg::CL_IDLE;
      vadc_pkg::CL_INTEG: cl_nxt = line_fall ? vadc_pkg::CL_CORRECT : vadc_pkg::CL_INTEG;
      vadc_pkg::CL_CORRECT: cl_nxt = line_rise ? vadc_pkg::CL_INTEG : vadc_pkg::CL_CORRECT;
      default: cl_nxt = vadc_pkg::CL_IDLE;
    endcase
  end
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      cl_r <= vadc_pkg::CL_IDLE;
    end else begin
      cl_r <= cl_nxt;
    end
  end
  always_ff @(posedge I_REF_CLK or negedge rst_n) begin
    if (!rst_n) begin
      sign_r <= vadc_pkg::CLAMP_NONE;
    end else if (cl_r == vadc_pkg::CL_INTEG && line_fall) begin
      sign_r <= I_CLAMP_SIGN;
    end
  end
  // no correction before the first sign is known
  assign O_CLAMP_INTEG = (cl_r == vadc_pkg::CL_INTEG);
  assign O_CLAMP_SOURCE = (cl_r == vadc_pkg::CL_CORRECT) ? sign_r : vadc_pkg::CLAMP_NONE;
  assign O_CLAMP_SINK = (cl_r == vadc_pkg::CL_CORRECT) ? ~sign_r : vadc_pkg::CLAMP_NONE;
  //////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge I_REF_CLK); endclocking
  default disable iff (!rst_n);
  a_select_drive: assert property (
    !I_SELECT_N |-> !O_CODE_OE_N ##0 (I_SELECT_N || !O_CODE_OE_N))
    else $error("outputs not driven while selected");
  a_out_on_rise: assert property (
    (O_RED_CODE != $past(O_RED_CODE)) |-> $past(s_rise))
    else $error("red code changed off a rising edge");
  a_cap_latency: assert property (
    s_rise |=> p2_r[vadc_pkg::CH_RED] == $past(p1_r[vadc_pkg::CH_RED]) &&
    p1_r[vadc_pkg::CH_RED] == $past(cap_r[vadc_pkg::CH_RED]))
    else $error("pipeline stage mismatch");
  a_out_from_p2: assert property (
    s_rise |=> O_GREEN_CODE == $past(p2_r[vadc_pkg::CH_GREEN]))
    else $error("green output not from second stage");
  a_dither_off: assert property (
    !dither_on_r |-> O_DITHER_HALF_LSB == vadc_pkg::DITHER_RST && !whole)
    else $error("dither active while disabled");
  a_cnt_frozen: assert property (
    (!I_FRAME_SYNC && !frame_r && !inc_pend_r && !rst_pend_r) |=> $stable(cnt_r))
    else $error("dither counter moved with frame sync low");
  a_frame_reset: assert property (
    rst_apply |=> cnt_r == vadc_pkg::DITHER_RST)
    else $error("dither counter not reset");
  a_line_step: assert property (
    (inc_apply && !rst_apply) |=> cnt_r == $past(cnt_r) + 2'h1)
    else $error("dither counter did not step");
  a_code_range: assert property (
    s_fall |=> cap_r[vadc_pkg::CH_GREEN] !=
    ($past(whole) ? vadc_pkg::CODE_MAX : vadc_pkg::CODE_MIN))
    else $error("code outside dither range");
  a_range_low: assert property (
    (s_fall && !whole) |=> cap_r[vadc_pkg::CH_RED] != vadc_pkg::CODE_MIN)
    else $error("code 00 with no whole-lsb offset");
  a_range_high: assert property (
    (s_fall && whole) |=> cap_r[vadc_pkg::CH_BLUE] != vadc_pkg::CODE_MAX)
    else $error("code ff with whole-lsb offset");
  a_rgb_levels: assert property (
    (!I_MODE && !I_MODE_OPEN) |-> O_CLAMP_LEVEL_RED == 8'h10 && O_CLAMP_LEVEL_BLUE == 8'h10)
    else $error("rgb clamp level wrong");
  a_luma_open: assert property (
    I_MODE_OPEN |-> O_CLAMP_LEVEL_GREEN == 8'h40 && O_CLAMP_LEVEL_RED == 8'h80)
    else $error("open-mode clamp level wrong");
  a_integ_start: assert property (
    (line_rise && cl_r != vadc_pkg::CL_INTEG) |=> O_CLAMP_INTEG)
    else $error("integration did not start");
  a_sign_latch: assert property (
    (cl_r == vadc_pkg::CL_INTEG && line_fall) |=> sign_r == $past(I_CLAMP_SIGN) &&
    O_CLAMP_SOURCE == sign_r)
    else $error("clamp sign not latched");
  a_no_drive_integ: assert property (
    O_CLAMP_INTEG |-> O_CLAMP_SOURCE == 3'h0 && O_CLAMP_SINK == 3'h0)
    else $error("clamp current during integration");
endmodule
`default_nettype wire

// file: vadc_sink_model.sv
`timescale 1ns/1ps
`default_nettype none
module vadc_sink_model (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic [vadc_pkg::WORD_W-1:0] i_data,
  input wire logic i_valid,
  input wire logic i_hold,
  input wire logic i_slow,
  output logic o_ready,
  output var int o_pops,
  output logic [vadc_pkg::WORD_W-1:0] o_last
);
  logic phase_r;
  // slow mode takes a word every other cycle, like a busy line store
  assign o_ready = !i_hold && (!i_slow || phase_r);
  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      phase_r <= 1'b0;
      o_pops <= 0;
      o_last <= '0;
    end else begin
      phase_r <= !phase_r;
      if (i_valid && o_ready) begin
        o_pops <= o_pops + 1;
        o_last <= i_data;
      end
    end
  end
endmodule
`default_nettype wire

// file: triple_video_adc_dither_clamp_ctrl_tb.sv
`timescale 1ns/1ps
`default_nettype none
module triple_video_adc_dither_clamp_ctrl_tb;
  logic ref_clk = 1'b0;
  logic arst_n = 1'b0;
  logic sclk = 1'b1;
  logic [1:0] sdiv = 2'h0;
  logic line_sync = 1'b0;
  logic frame_sync = 1'b0;
  logic select_n = 1'b0;
  logic mode = 1'b0;
  logic mode_open = 1'b0;
  logic [255:0] red_th = '0;
  logic [255:0] green_th = '0;
  logic [255:0] blue_th = '0;
  logic [2:0] clamp_sign = 3'h0;
  logic hold = 1'b0;
  logic slow = 1'b0;
  logic ready;
  logic [7:0] red_code, green_code, blue_code, lvl_r, lvl_g, lvl_b;
  logic oe_n, dith_on, integ, fifo_rdy, valid;
  logic [1:0] dith;
  logic [2:0] src, snk;
  logic [23:0] data, last;
  int pops;
  int fails = 0;
  int n_compared = 0;
  int cycles = 0;

  vadc_ctrl u_vadc_ctrl (
    .I_REF_CLK(ref_clk), .I_ARST_N(arst_n), .I_SAMPLE_CLK(sclk),
    .I_LINE_SYNC(line_sync), .I_FRAME_SYNC(frame_sync), .I_SELECT_N(select_n),
    .I_MODE(mode), .I_MODE_OPEN(mode_open), .I_RED_THERM(red_th),
    .I_GREEN_THERM(green_th), .I_BLUE_THERM(blue_th), .I_CLAMP_SIGN(clamp_sign),
    .I_STREAM_READY(ready), .O_RED_CODE(red_code), .O_GREEN_CODE(green_code),
    .O_BLUE_CODE(blue_code), .O_CODE_OE_N(oe_n), .O_DITHER_HALF_LSB(dith),
    .O_DITHER_ON(dith_on), .O_CLAMP_LEVEL_RED(lvl_r), .O_CLAMP_LEVEL_GREEN(lvl_g),
    .O_CLAMP_LEVEL_BLUE(lvl_b), .O_CLAMP_INTEG(integ), .O_CLAMP_SOURCE(src),
    .O_CLAMP_SINK(snk), .O_STREAM_DATA(data), .O_STREAM_VALID(valid),
    .O_FIFO_READY(fifo_rdy)
  );
  vadc_sink_model u_vadc_sink_model (
    .i_clk(ref_clk), .i_rst_n(arst_n), .i_data(data), .i_valid(valid),
    .i_hold(hold), .i_slow(slow), .o_ready(ready), .o_pops(pops), .o_last(last)
  );
  ////////////////////////////////////////////////////////////////////////
  always #2 ref_clk = ~ref_clk;
  // sample clock of 8 ref cycles, well above the 2-cycle minimum phase
  always @(negedge ref_clk) begin
    sdiv <= sdiv + 2'h1;
    if (sdiv == 2'h3) begin
      sclk <= ~sclk;
    end
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 4000) begin // over four times the expected run
      fails++;
      results();
    end
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic results();
    $display("compared %0d, failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic waitn(input int n);
    repeat (n) @(negedge ref_clk);
  endtask
  function automatic logic [255:0] therm(input logic [7:0] n);
    logic [255:0] t;
    t = '0;
    for (int i = 1; i <= 255; i++) begin
      if (i <= n) t[i] = 1'b1;
    end
    return t;
  endfunction
  // whole-lsb offset only when count msb set; floor keeps 00
  function automatic logic [7:0] corr(input logic [7:0] raw, input logic [1:0] cnt);
    if (cnt[1]) return (raw == 8'h00) ? 8'h00 : raw - 8'h01;
    return (raw == 8'h00) ? 8'h01 : raw;
  endfunction
  task automatic set_codes(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b);
    red_th = therm(r);
    green_th = therm(g);
    blue_th = therm(b);
  endtask
  task automatic codes_ok(input logic [7:0] r, input logic [7:0] g, input logic [7:0] b,
                          input logic [1:0] cnt);
    set_codes(r, g, b);
    waitn(40);
    check("red code", red_code, corr(r, cnt));
    check("green code", green_code, corr(g, cnt));
    check("blue code", blue_code, corr(b, cnt));
  endtask
  task automatic line_pulse(input logic [2:0] sign);
    line_sync = 1'b1;
    waitn(3);
    check("integrate", integ, 1'b1);
    clamp_sign = sign;
    line_sync = 1'b0;
    waitn(3);
    check("integrate off", integ, 1'b0);
    check("clamp source", src, sign);
    check("clamp sink", snk, 3'(~sign));
    waitn(12);
  endtask
  task automatic frame_pulse(input logic [1:0] expv);
    frame_sync = 1'b0;
    waitn(12);
    check("dither frozen", dith, 2'h0);
    check("dither off", dith_on, 1'b0);
    line_pulse(3'b110);
    frame_sync = 1'b1;
    waitn(12);
    check("dither after frame", dith, expv);
    check("dither on", dith_on, 1'b1);
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_select();
    select_n = 1'b1;
    waitn(1);
    check("oe_n high", oe_n, 1'b1);
    select_n = 1'b0;
    waitn(1);
    check("oe_n low", oe_n, 1'b0);
  endtask
  task automatic t_clamp();
    logic [7:0] lg, lc;
    for (int m = 0; m < 4; m++) begin
      mode = m[0];
      mode_open = m[1];
      waitn(1);
      lg = mode_open ? vadc_pkg::CLAMP_QTR : vadc_pkg::CLAMP_LOW;
      lc = (mode || mode_open) ? vadc_pkg::CLAMP_MID : vadc_pkg::CLAMP_LOW;
      check("clamp green", lvl_g, lg);
      check("clamp red", lvl_r, lc);
      check("clamp blue", lvl_b, lc);
    end
    mode = 1'b0;
    mode_open = 1'b0;
  endtask
  task automatic t_latency();
    codes_ok(8'h11, 8'h22, 8'h33, 2'h0);
    @(negedge sclk);
    set_codes(8'h44, 8'h55, 8'h66);
    // codes move on the ref edge that sees the third rise, just after this
    repeat (3) @(posedge sclk);
    check("red too early", red_code, 8'h11);
    @(negedge ref_clk);
    check("red latency", red_code, 8'h44);
    check("green latency", green_code, 8'h55);
    check("blue latency", blue_code, 8'h66);
  endtask
  task automatic t_dither();
    logic [1:0] c;
    for (int k = 1; k <= 4; k++) begin
      c = k[1:0];
      line_pulse(c[0] ? 3'b101 : 3'b010);
      check("dither step", dith, c);
      check("dither enabled", dith_on, 1'b1);
      codes_ok(8'h00, 8'hff, 8'h5a, c);
    end
  endtask
  task automatic t_frame();
    line_pulse(3'b001);
    frame_pulse(2'h0);
    line_pulse(3'b011);
    line_pulse(3'b100);
    frame_pulse(2'h2);
    frame_pulse(2'h0);
  endtask
  task automatic t_fifo();
    int base;
    int k;
    codes_ok(8'h12, 8'h34, 8'h56, 2'h0);
    hold = 1'b1;
    k = 0;
    while (fifo_rdy !== 1'b0 && k < 600) begin
      waitn(1);
      k++;
    end
    check("fifo full", fifo_rdy, 1'b0);
    check("valid while full", valid, 1'b1);
    check("head word", data, 24'h563412);
    base = pops;
    hold = 1'b0;
    slow = 1'b1;
    k = 0;
    while (valid !== 1'b0 && k < 600) begin
      waitn(1);
      k++;
    end
    check("fifo empty", valid, 1'b0);
    check("words drained", (pops - base) >= 32, 1'b1);
    check("last word", last, 24'h563412);
    slow = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    waitn(7);
    check("reset red", red_code, 8'h00);
    check("reset valid", valid, 1'b0);
    check("reset fifo ready", fifo_rdy, 1'b1);
    check("reset dither", dith, 2'h0);
    check("reset clamp", {integ, src, snk}, 7'h00);
    waitn(1);
    arst_n = 1'b1;
    waitn(4);
    // first frame pulse after reset: counter keeps its zero
    frame_sync = 1'b1;
    waitn(12);
    t_select();
    t_clamp();
    t_latency();
    t_dither();
    t_frame();
    t_fifo();
    results();
  end
endmodule
`default_nettype wire
